// ### verilog/ccg_map.svh
/*
  Register map, field positions, codes and timing figures of the CPU clock
  select generator. Assumes it is included by bare name from the package only;
  the design files use its macros without including it.
*/
// Contract
// - The CPU clock is the main oscillator undivided, divided by 2, 4, 8 or 16, or the sub oscillator, as software selects.
// - After reset the selection is the slowest main-derived setting, the main oscillator divided by 16.
// - A new CPU clock selection is taken at any time and applied without reset or halt.
// - The watch timer clock and the programmable clock output each follow their own main or sub source select.
// - All other peripherals are clocked from the main oscillator only.
// - The shortest instruction takes four CPU clock periods, marked by one instruction tick per four periods.
// - The CPU clock source, main or sub, is chosen through the CPU clock control register.
// - A three-bit settle select picks a wait of 2^13, 2^15, 2^16, 2^17 or 2^18 main periods after stop release.
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------------
`define CCG_ADDR_W 8
`define CCG_OFS_CTRL 8'h00
`define CCG_OFS_SETTLE 8'h04
`define CCG_OFS_STATUS 8'h08
`define CCG_CTRL_WSRC 3
`define CCG_CTRL_OSRC 4
`define CCG_STAT_PEND 3
`define CCG_STAT_BUSY 4
`define CCG_RESP_OKAY 2'h0
`define CCG_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------------
// Clock selection codes
// ----------------------------------------------------------------------------
`define CCG_SEL_DIV1 3'h0
`define CCG_SEL_DIV2 3'h1
`define CCG_SEL_DIV4 3'h2
`define CCG_SEL_DIV8 3'h3
`define CCG_SEL_DIV16 3'h4
`define CCG_SEL_SUB 3'h5
`define CCG_SEL_RESET `CCG_SEL_DIV16

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CCG_INSTR_LAST 2'h3
`define CCG_SETTLE_LAST_CODE 3'h4
`define CCG_SETTLE_RESET 3'h4
`define CCG_SETTLE_EXP0 13
`define CCG_SETTLE_EXP1 15
`define CCG_SETTLE_EXP2 16
`define CCG_SETTLE_EXP3 17
`define CCG_SETTLE_EXP4 18
`define CCG_SETTLE_CNT_W 19

`endif

// ### verilog/ccg_pkg.sv
/*
  Types of the CPU clock select generator: settle state and the state records
  of the top module and the edge detector. Assumes ccg_map.svh is reachable.
*/
`include "ccg_map.svh"
package ccg_pkg;

  typedef enum logic [0:0] {SW_IDLE, SW_WAIT} ccg_settle_t;

  typedef struct packed {
    logic prev;
  } ccg_edge_st_t;

  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] req;
    logic wsrc;
    logic osrc;
    logic [2:0] settle_wait_select_register;
    logic cpu;
    logic [3:0] half;
    logic [1:0] cyc;
    logic tick;
    logic periph;
    logic wclk;
    logic pclk;
    ccg_settle_t sw;
    logic [`CCG_SETTLE_CNT_W-1:0] scnt;
    logic [`CCG_SETTLE_CNT_W-1:0] slim;
    logic done;
    logic aw_ok;
    logic [`CCG_ADDR_W-1:0] awa;
    logic w_ok;
    logic [31:0] wdat;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccg_st_t;

endpackage : ccg_pkg

// ### verilog/ccg_edge_det.sv
/*
  Edge detector for one oscillator level. Assumes the level is synchronous
  to clk and slower than half the clk rate.
*/
`timescale 1ns/1ps
`default_nettype none
module ccg_edge_det (
  input wire logic clk,
  input wire logic srst,
  input wire logic lvl,
  output logic any_edge,
  output logic rise
);
  import ccg_pkg::*;

  ccg_edge_st_t q, d;

  always_comb begin
    d = q;
    d.prev = lvl;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign any_edge = lvl ^ q.prev;
  assign rise = lvl & ~q.prev;
endmodule : ccg_edge_det
`default_nettype wire

// ### verilog/ccg_top.sv
/*
  CPU clock select generator with an AXI4-Lite register slave. Holds the
  CPU clock divider and source switch, the instruction tick, the peripheral,
  watch and clock-out routing and the stop-release settle wait. Assumes the
  oscillator inputs are levels synchronous to clk, at most a quarter of its rate.
*/
`timescale 1ns/1ps
`default_nettype none
module ccg_top #(
  parameter logic [4:0] SETTLE_EXP0 = 5'(`CCG_SETTLE_EXP0),
  parameter logic [4:0] SETTLE_EXP1 = 5'(`CCG_SETTLE_EXP1),
  parameter logic [4:0] SETTLE_EXP2 = 5'(`CCG_SETTLE_EXP2),
  parameter logic [4:0] SETTLE_EXP3 = 5'(`CCG_SETTLE_EXP3),
  parameter logic [4:0] SETTLE_EXP4 = 5'(`CCG_SETTLE_EXP4)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`CCG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CCG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  input wire logic stop_release,
  output logic cpu_clk_out,
  output logic instr_tick,
  output logic periph_clk_out,
  output logic watch_clk_out,
  output logic programmable_clock_out,
  output logic settle_busy,
  output logic settle_done
);
  import ccg_pkg::*;

  ccg_st_t q, d;
  logic main_edge;
  logic main_rise;
  logic sub_edge;
  logic toggle;
  logic [3:0] half_last;

  // ----------------------------------------------------------------------------
  // Oscillator edges
  // ----------------------------------------------------------------------------
  ccg_edge_det u_main_edge (
    .clk(clk),
    .srst(srst),
    .lvl(main_osc_in),
    .any_edge(main_edge),
    .rise(main_rise)
  );

  ccg_edge_det u_sub_edge (
    .clk(clk),
    .srst(srst),
    .lvl(sub_osc_in),
    .any_edge(sub_edge),
    .rise()
  );

  function automatic logic [`CCG_SETTLE_CNT_W-1:0] settle_last(input logic [2:0] code);
    logic [4:0] e;
    e = SETTLE_EXP4;
    case (code)
      3'h0: e = SETTLE_EXP0;
      3'h1: e = SETTLE_EXP1;
      3'h2: e = SETTLE_EXP2;
      3'h3: e = SETTLE_EXP3;
      default: e = SETTLE_EXP4;
    endcase
    settle_last = (`CCG_SETTLE_CNT_W'(1) << e) - `CCG_SETTLE_CNT_W'(1);
  endfunction : settle_last

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    d = q;
    toggle = 1'b0;
    d.tick = 1'b0;
    d.done = 1'b0;
    // Each half period of fX/2^n spans 2^n main half periods, so the
    // divider counts both main edges; divide by one simply follows the input.
    half_last = 4'((5'h1 << q.sel) - 5'h1);
    d.periph = main_osc_in;
    d.wclk = q.wsrc ? sub_osc_in : main_osc_in;
    d.pclk = q.osrc ? sub_osc_in : main_osc_in;
    if (q.sel == `CCG_SEL_SUB) begin
      // The sub input is followed only after one of its falling edges, so the
      // low phase that starts at the switch is never cut short.
      if (q.half == '0) begin
        if (sub_edge && !sub_osc_in) begin
          d.half = 4'h1;
        end
      end else begin
        toggle = sub_edge;
      end
    end else if (main_edge) begin
      if (q.half == half_last) begin
        toggle = 1'b1;
        d.half = '0;
      end else begin
        d.half = q.half + 4'h1;
      end
    end
    if (toggle) begin
      d.cpu = ~q.cpu;
      if (q.cpu) begin
        // A new setting is only taken at the end of a whole period, so the
        // phase just finished and the next one both have their full length.
        d.sel = q.req;
        if (q.req != q.sel) begin
          d.half = '0;
        end
      end else begin
        d.cyc = q.cyc + 2'h1;
        if (q.cyc == `CCG_INSTR_LAST) begin
          d.tick = 1'b1;
        end
      end
    end

    case (q.sw)
      SW_IDLE: begin
        if (stop_release) begin
          d.sw = SW_WAIT;
          d.scnt = '0;
          d.slim = settle_last(q.settle_wait_select_register);
        end
      end
      SW_WAIT: begin
        if (main_rise) begin
          if (q.scnt == q.slim) begin
            d.sw = SW_IDLE;
            d.done = 1'b1;
          end else begin
            d.scnt = q.scnt + `CCG_SETTLE_CNT_W'(1);
          end
        end
      end
      default: d.sw = SW_IDLE;
    endcase

    // ----------------------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------------------
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_awvalid && !q.aw_ok) begin
      d.aw_ok = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_ok) begin
      d.w_ok = 1'b1;
      d.wdat = s_axi_wdata;
      d.wstb = s_axi_wstrb[0];
    end
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `CCG_RESP_OKAY;
      case (q.awa)
        `CCG_OFS_CTRL: begin
          if (q.wstb) begin
            if (q.wdat[2:0] <= `CCG_SEL_SUB) begin
              d.req = q.wdat[2:0];
            end
            d.wsrc = q.wdat[`CCG_CTRL_WSRC];
            d.osrc = q.wdat[`CCG_CTRL_OSRC];
          end
        end
        `CCG_OFS_SETTLE: begin
          if (q.wstb && q.wdat[2:0] <= `CCG_SETTLE_LAST_CODE) begin
            d.settle_wait_select_register = q.wdat[2:0];
          end
        end
        default: d.bresp = `CCG_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = `CCG_RESP_OKAY;
      d.rdata = '0;
      case (s_axi_araddr)
        `CCG_OFS_CTRL: begin
          d.rdata[2:0] = q.req;
          d.rdata[`CCG_CTRL_WSRC] = q.wsrc;
          d.rdata[`CCG_CTRL_OSRC] = q.osrc;
        end
        `CCG_OFS_SETTLE: d.rdata[2:0] = q.settle_wait_select_register;
        `CCG_OFS_STATUS: begin
          d.rdata[2:0] = q.sel;
          d.rdata[`CCG_STAT_PEND] = (q.req != q.sel);
          d.rdata[`CCG_STAT_BUSY] = (q.sw == SW_WAIT);
        end
        default: d.rresp = `CCG_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.sel <= `CCG_SEL_RESET;
      q.req <= `CCG_SEL_RESET;
      q.settle_wait_select_register <= `CCG_SETTLE_RESET;
      q.sw <= SW_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign s_axi_awready = !q.aw_ok;
  assign s_axi_wready = !q.w_ok;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign cpu_clk_out = q.cpu;
  assign instr_tick = q.tick;
  assign periph_clk_out = q.periph;
  assign watch_clk_out = q.wclk;
  assign programmable_clock_out = q.pclk;
  assign settle_busy = (q.sw == SW_WAIT);
  assign settle_done = q.done;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  logic [2:0] rise_h;
  always_ff @(posedge clk) begin
    if (srst) begin
      rise_h <= '0;
    end else if (q.cpu && !$past(q.cpu)) begin
      rise_h <= q.tick ? 3'h0 : rise_h + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  reset_default_a: assert property ($past(srst) |-> q.sel == `CCG_SEL_DIV16 && !q.cpu)
    else $error("selection after reset is not the slow main setting");
  apply_on_fall_a: assert property ($changed(q.sel) |-> $fell(q.cpu))
    else $error("selection changed outside a falling cpu clock edge");
  req_store_a: assert property (s_axi_bvalid && !$past(s_axi_bvalid) && $past(q.awa) == `CCG_OFS_CTRL
    && $past(q.wstb) && $past(q.wdat[2:0]) <= `CCG_SEL_SUB |-> q.req == $past(q.wdat[2:0]))
    else $error("accepted selection not stored");
  div1_follow_a: assert property (q.sel == `CCG_SEL_DIV1 && $past(q.sel) == `CCG_SEL_DIV1
    && $changed(q.cpu) |-> $past(main_edge))
    else $error("divide by one does not follow the main oscillator");
  sub_follow_a: assert property (q.sel == `CCG_SEL_SUB && $past(q.sel) == `CCG_SEL_SUB
    && $changed(q.cpu) |-> $past(sub_edge))
    else $error("sub selection does not follow the sub oscillator");
  periph_main_a: assert property (##1 periph_clk_out == $past(main_osc_in))
    else $error("peripheral clock not taken from the main oscillator");
  watch_src_a: assert property (##1 watch_clk_out == ($past(q.wsrc) ? $past(sub_osc_in) : $past(main_osc_in)))
    else $error("watch clock does not follow its source select");
  instr_four_a: assert property (instr_tick |-> $rose(q.cpu) && rise_h == 3'h3)
    else $error("instruction tick not on the fourth cpu clock period");
  settle_len_a: assert property ($fell(settle_busy) |-> settle_done && $past(q.scnt) == $past(q.slim))
    else $error("settle wait ended early");

  sub_switch_c: cover property ($changed(q.sel) && q.sel == `CCG_SEL_SUB);
  tick_c: cover property (instr_tick);
  settle_c: cover property (settle_done);
endmodule : ccg_top
`default_nettype wire

// ### dv/ccg_top_tb.sv
/*
  Self-checking bench of the CPU clock select generator top. Assumes ccg_pkg
  and ccg_top are compiled first and that the oscillators are slow sampled levels.
*/
`timescale 1ns/1ps
`default_nettype none
module ccg_top_tb;
  import ccg_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus and monitor state
  // ---------------------------------------------------------------------------
  logic clk, srst, stop_release, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic main_osc_in = 1'b0;
  logic sub_osc_in = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cpu_clk_out, instr_tick, periph_clk_out, watch_clk_out, programmable_clock_out, settle_busy, settle_done;
  logic cpu_prev, main_prev;
  int failures, total_checks, plen, rises, run, mdiv, sdiv;

  ccg_top #(.SETTLE_EXP0(5'h2), .SETTLE_EXP1(5'h3), .SETTLE_EXP2(5'h4), .SETTLE_EXP3(5'h5), .SETTLE_EXP4(5'h6)) dut (
    .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_osc_in, .sub_osc_in, .stop_release,
    .cpu_clk_out, .instr_tick, .periph_clk_out, .watch_clk_out, .programmable_clock_out, .settle_busy, .settle_done);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Main toggles every 2 cycles, sub every 5, so each ratio has its own period.
  always @(posedge clk) begin
    mdiv = (mdiv + 1) % 2;
    sdiv = (sdiv + 1) % 5;
    if (mdiv == 0) main_osc_in <= ~main_osc_in;
    if (sdiv == 0) sub_osc_in <= ~sub_osc_in;
  end

  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  // ---------------------------------------------------------------------------
  // Continuous watch of phases, ticks and peripheral clock
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    run = srst ? 0 : run + 1;
    if (run < 3) begin
      plen = 1;
      rises = 0;
    end else begin
      if (cpu_clk_out !== cpu_prev) begin
        if (plen < 2) chk(1'b0, "short cpu clock phase");
        plen = 1;
      end else plen++;
      if (cpu_clk_out === 1'b1 && cpu_prev === 1'b0) rises++;
      if (instr_tick === 1'b1) begin
        chk(rises == 4 && cpu_clk_out === 1'b1 && cpu_prev === 1'b0, "instruction tick spacing");
        rises = 0;
      end
      if (periph_clk_out !== main_prev) chk(1'b0, "peripheral clock not main");
    end
    cpu_prev = cpu_clk_out;
    main_prev = main_osc_in;
  end

  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit ad, wd;
    n = 0;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && wd) && n < 100);
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (n >= 200) chk(1'b0, "write timeout");
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (n >= 200) chk(1'b0, "read timeout");
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  task automatic wait_rise(output int c);
    logic p;
    c = 0;
    p = cpu_clk_out;
    do begin
      @(posedge clk);
      c++;
      if (cpu_clk_out === 1'b1 && p === 1'b0) break;
      p = cpu_clk_out;
    end while (c < 400);
  endtask : wait_rise

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    int c;
    axi_rd(8'h00, d, r);
    chk(d === 32'h4 && r === 2'h0, "control reset value");
    axi_rd(8'h08, d, r);
    chk(d === 32'h4, "status reset value");
    axi_rd(8'h04, d, r);
    chk(d === 32'h4, "settle reset value");
    axi_rd(8'h0C, d, r);
    chk(r === 2'h2, "unmapped read response");
    axi_wr(8'h08, 32'h0, r);
    chk(r === 2'h2, "status write response");
    wait_rise(c);
    wait_rise(c);
    chk(c == 64, "reset cpu period");
    $display("test regs done");
  endtask : t_regs

  task automatic t_ratio;
    logic [31:0] d;
    logic [1:0] r;
    int c;
    for (int k = 0; k < 6; k++) begin
      axi_wr(8'h00, 32'(k), r);
      chk(r === 2'h0, "control write response");
      wait_rise(c);
      wait_rise(c);
      wait_rise(c);
      chk(c == (k == 5 ? 10 : 4 << k), "cpu clock period");
      axi_rd(8'h08, d, r);
      chk(d[2:0] === 3'(k), "applied selection");
    end
    axi_wr(8'h00, 32'h6, r);
    axi_rd(8'h00, d, r);
    chk(d[2:0] === 3'h5, "undefined selection ignored");
    s_axi_wstrb <= 4'h0;
    axi_wr(8'h00, 32'h0, r);
    s_axi_wstrb <= 4'hF;
    axi_rd(8'h00, d, r);
    chk(d[2:0] === 3'h5, "strobe-less write ignored");
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    axi_rd(8'h08, d, r);
    chk(d[2:0] === 3'h4, "selection after second reset");
    $display("test ratio done");
  endtask : t_ratio

  task automatic t_route;
    logic [1:0] r;
    logic mp, sp;
    bit ok;
    for (int k = 0; k < 2; k++) begin
      axi_wr(8'h00, k ? 32'hC : 32'h14, r);
      repeat (3) @(posedge clk);
      mp = main_osc_in;
      sp = sub_osc_in;
      ok = 1;
      repeat (40) begin
        @(posedge clk);
        if (watch_clk_out !== (k ? sp : mp) || programmable_clock_out !== (k ? mp : sp)) ok = 0;
        mp = main_osc_in;
        sp = sub_osc_in;
      end
      chk(ok, "watch or clock-out source");
    end
    $display("test route done");
  endtask : t_route

  task automatic t_settle;
    logic [31:0] d;
    logic [1:0] r;
    logic p;
    int n, mr;
    for (int k = 0; k < 5; k++) begin
      axi_wr(8'h04, 32'(k), r);
      stop_release <= 1'b1;
      @(posedge clk);
      stop_release <= 1'b0;
      @(posedge clk);
      chk(settle_busy === 1'b1, "settle busy after release");
      n = 0;
      mr = 0;
      p = main_osc_in;
      do begin
        @(posedge clk);
        n++;
        if (main_osc_in === 1'b1 && p === 1'b0) mr++;
        p = main_osc_in;
      end while (settle_done !== 1'b1 && n < 1000);
      chk(settle_busy === 1'b0 && mr >= (1 << (k + 2)) - 1 && mr <= (1 << (k + 2)) + 1, "settle length");
    end
    axi_wr(8'h04, 32'h5, r);
    axi_rd(8'h04, d, r);
    chk(d[2:0] === 3'h4, "undefined settle code ignored");
    $display("test settle done");
  endtask : t_settle

  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    srst = 1'b1;
    stop_release = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk);
    chk(cpu_clk_out === 1'b0 && settle_busy === 1'b0, "outputs in reset");
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_ratio();
    t_route();
    t_settle();
    complete_run();
  end
endmodule : ccg_top_tb
`default_nettype wire
